// file: include/pxp1_map.svh
/*
 * Offsets, field positions, reset values and codes of the extended page 1
 * register bank. Assumes AXI4-Lite byte addresses of four times the index.
 */
// Summary of operation
// R1: Writing 0x0001 to page select register 31 maps extended page 1 into window.
// R2: Writing 0x0000 to page select returns the window to the main registers.
// R3: With page 1 selected, addresses 16 to 30 reach the page 1 registers.
// R4: Addresses 0 to 15 map the same way whatever page is selected.
// R5: Counter bit 15 shows a packet arrived since last read; read clears it.
// R6: Bits 13:0 count good-CRC packets modulo 10,000, wrapping after 9,999.
// R7: Reading the counter register clears the count field.
// R8: Bits 15:12 each put one LED into basic serial LED mode.
// R9: Bit 11 set blinks LEDs after power-hold release; clear suppresses blink.
// R10: Bit 4 enables fast link failure pin; program only through port zero.
// R11: Bits 3:2 select auto, forced MDI (10) or forced MDI-X (11); 01 reserved.
// R12: Bit 15 of third register, default 1, disables gigabit carrier extension.
// R13: Sleep timer bits 14:13 select 1 to 4 seconds; default code 01.
// R14: Wake timer bits 12:11 select 160, 400, 800 ms or 2 s; default 00.
// R15: Bit 10 tells the device the management clock is below 10 MHz.
// R16: Bit 9 swaps port addresses; set from port 0, cleared from port 1.
// R17: Read-only bits 7:6 report media: 00 none, 01 copper.
// R18: Bit 5 asserts receive-valid in 10BASE-T without preamble.
// R19: Bit 4 of third register enables automatic gigabit speed downshift.
// R20: Bits 3:2 downshift after 2, 3, 4 or 5 failed gigabit attempts.
// R21: Sticky fields survive software reset; only hardware reset restores them.
`ifndef PXP1_MAP_SVH
`define PXP1_MAP_SVH
`define PXP1_IDX_CRC_CNT      5'h12
`define PXP1_IDX_MODE_CTL     5'h13
`define PXP1_IDX_SLEEP_CTL    5'h14
`define PXP1_IDX_PAGE_SEL     5'h1F
`define PXP1_IDX_PAGED_LO     5'h10
`define PXP1_PAGE_MAIN        16'h0000
`define PXP1_PAGE_EXT1        16'h0001
`define PXP1_ADDR_SPAN        7
`define PXP1_CNT_MAX          14'h270F
`define PXP1_MODE_CTL_RST     16'h0000
`define PXP1_SLEEP_CTL_RST    16'hA004
`define PXP1_MODE_CTL_WMASK   16'hF81D
`define PXP1_SLEEP_CTL_WMASK  16'hFE3C
`define PXP1_B_PKT_SEEN       15
`define PXP1_B_LED_HI         15
`define PXP1_B_LED_LO         12
`define PXP1_B_BLINK          11
`define PXP1_B_FLF            4
`define PXP1_B_MDI_HI         3
`define PXP1_B_MDI_LO         2
`define PXP1_B_CEXT_DIS       15
`define PXP1_B_SLEEP_HI       14
`define PXP1_B_SLEEP_LO       13
`define PXP1_B_WAKE_HI        12
`define PXP1_B_WAKE_LO        11
`define PXP1_B_SLOW_MDC       10
`define PXP1_B_ADDR_REV       9
`define PXP1_B_MEDIA_HI       7
`define PXP1_B_MEDIA_LO       6
`define PXP1_B_NO_PREAMBLE    5
`define PXP1_B_DS_EN          4
`define PXP1_B_DS_HI          3
`define PXP1_B_DS_LO          2
`define PXP1_SLEEP_BASE_S     3'h1
`define PXP1_DS_BASE_TRIES    3'h2
`define PXP1_WAKE_160_MS      12'h0A0
`define PXP1_WAKE_400_MS      12'h190
`define PXP1_WAKE_800_MS      12'h320
`define PXP1_WAKE_2000_MS     12'h7D0
`define PXP1_RESP_OKAY        2'h0
`define PXP1_RESP_SLVERR      2'h2
`endif

// file: include/pxp1_pkg.sv
/*
 * Types of the extended page 1 register bank.
 * Assumes the constants of pxp1_map.svh.
 */
package pxp1_pkg;
    typedef enum logic [1:0] {
        PXP1_MDI_AUTO,
        PXP1_MDI_RSVD,
        PXP1_MDI_FORCE_MDI,
        PXP1_MDI_FORCE_MDIX
    } pxp1_mdi_e;

    typedef struct packed {
        logic [15:0] page_sel;
        logic        pkt_seen;
        logic [13:0] crc_cnt;
        logic [15:0] mode_ctl;
        logic [15:0] sleep_ctl;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        hold_s1;
        logic        hold_s2;
        logic        hold_d;
        logic        port0_s1;
        logic        port0_s2;
        logic        blink;
    } pxp1_state_s;
endpackage : pxp1_pkg

// file: rtl/pxp1_regs.sv
/*
 * Extended page 1 register bank behind an AXI4-Lite slave: page select,
 * good-CRC packet counter, LED/mode control and sleep/downshift control.
 * Assumes good_crc_pkt and media_status come from logic on clk; the
 * power-hold and port-zero strap pins are asynchronous and synchronised here.
 */
`timescale 1ns/1ps
`include "pxp1_map.svh"

module pxp1_regs (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        soft_rst,
    input  wire logic [6:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [6:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        good_crc_pkt,
    input  wire logic [1:0]  media_status,
    input  wire logic        power_hold_input,
    input  wire logic        port_zero_pin,
    output logic             page1_active,
    output logic [3:0]       led_serial_mode,
    output logic             led_release_blink,
    output logic             fast_link_fail_en,
    output pxp1_pkg::pxp1_mdi_e mdi_mode,
    output logic             carrier_ext_disable,
    output logic [2:0]       sleep_seconds,
    output logic [11:0]      wake_ms,
    output logic             slow_mgmt_clk,
    output logic             port_addr_swap,
    output logic             no_preamble_10bt,
    output logic             downshift_en,
    output logic [2:0]       downshift_tries
);
    localparam logic [15:0] sleep_ctl_rst = `PXP1_SLEEP_CTL_RST;

    pxp1_pkg::pxp1_state_s st_ff;
    pxp1_pkg::pxp1_state_s nxt_st;

    logic        wr_go;
    logic        rd_go;
    logic [4:0]  wr_idx;
    logic [4:0]  rd_idx;
    logic        wr_ok;
    logic        rd_ok;
    logic [15:0] wr_mask;
    logic [15:0] rd_val;
    logic        pg1;

    assign pg1           = (st_ff.page_sel == `PXP1_PAGE_EXT1); // R1 R2
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !st_ff.bvalid;
    assign rd_go         = s_axi_arvalid && !st_ff.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign wr_idx        = s_axi_awaddr[6:2];
    assign rd_idx        = s_axi_araddr[6:2];
    assign wr_ok         = (s_axi_awaddr[1:0] == 2'h0);
    assign rd_ok         = (s_axi_araddr[1:0] == 2'h0);
    assign wr_mask       = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    // Read mux; paged indexes reach page 1 only while it is selected
    always_comb begin
        rd_val = 16'h0000;
        if (rd_idx == `PXP1_IDX_PAGE_SEL) begin
            rd_val = st_ff.page_sel;
        end else if (pg1 && rd_idx >= `PXP1_IDX_PAGED_LO) begin // R3 R4
            unique case (rd_idx)
                `PXP1_IDX_CRC_CNT: begin
                    rd_val = {st_ff.pkt_seen, 1'b0, st_ff.crc_cnt}; // R5 R6
                end
                `PXP1_IDX_MODE_CTL: begin
                    rd_val = st_ff.mode_ctl;
                end
                `PXP1_IDX_SLEEP_CTL: begin
                    rd_val = st_ff.sleep_ctl;
                    rd_val[`PXP1_B_MEDIA_HI:`PXP1_B_MEDIA_LO] = media_status; // R17
                end
                default: begin
                    rd_val = 16'h0000;
                end
            endcase
        end
    end

    always_comb begin
        nxt_st = st_ff;

        nxt_st.hold_s1  = power_hold_input;
        nxt_st.hold_s2  = st_ff.hold_s1;
        nxt_st.hold_d   = st_ff.hold_s2;
        nxt_st.port0_s1 = port_zero_pin;
        nxt_st.port0_s2 = st_ff.port0_s1;
        // One-cycle blink request on release of the power-hold input
        nxt_st.blink = st_ff.hold_d && !st_ff.hold_s2
                       && st_ff.mode_ctl[`PXP1_B_BLINK]; // R9

        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end

        if (wr_go) begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = wr_ok ? `PXP1_RESP_OKAY : `PXP1_RESP_SLVERR;
            if (wr_ok && wr_idx == `PXP1_IDX_PAGE_SEL) begin
                nxt_st.page_sel = (st_ff.page_sel & ~wr_mask)
                                  | (s_axi_wdata[15:0] & wr_mask); // R1 R2
            end else if (wr_ok && pg1 && wr_idx == `PXP1_IDX_MODE_CTL) begin // R3
                nxt_st.mode_ctl = (st_ff.mode_ctl & ~(wr_mask & `PXP1_MODE_CTL_WMASK))
                    | (s_axi_wdata[15:0] & wr_mask & `PXP1_MODE_CTL_WMASK); // R8 R10 R11
            end else if (wr_ok && pg1 && wr_idx == `PXP1_IDX_SLEEP_CTL) begin // R3
                nxt_st.sleep_ctl = (st_ff.sleep_ctl & ~(wr_mask & `PXP1_SLEEP_CTL_WMASK))
                    | (s_axi_wdata[15:0] & wr_mask & `PXP1_SLEEP_CTL_WMASK); // R12 R13
            end
        end

        if (rd_go) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = rd_ok ? `PXP1_RESP_OKAY : `PXP1_RESP_SLVERR;
            nxt_st.rdata  = rd_ok ? {16'h0000, rd_val} : 32'h0000_0000;
            if (rd_ok && pg1 && rd_idx == `PXP1_IDX_CRC_CNT) begin
                nxt_st.pkt_seen = 1'b0; // R5
                nxt_st.crc_cnt  = 14'h0000; // R7
            end
        end

        // Software reset clears only non-sticky state
        if (soft_rst) begin
            nxt_st.pkt_seen = 1'b0;
            nxt_st.crc_cnt  = 14'h0000;
            nxt_st.sleep_ctl[`PXP1_B_CEXT_DIS] = sleep_ctl_rst[`PXP1_B_CEXT_DIS]; // R21
        end

        // A packet in the cycle of a clearing read is counted afterwards
        if (good_crc_pkt) begin
            nxt_st.pkt_seen = 1'b1; // R5
            if (rd_go && rd_ok && pg1 && rd_idx == `PXP1_IDX_CRC_CNT) begin
                nxt_st.crc_cnt = 14'h0001; // R7
            end else if (soft_rst) begin
                nxt_st.crc_cnt = 14'h0001;
            end else if (st_ff.crc_cnt == `PXP1_CNT_MAX) begin
                nxt_st.crc_cnt = 14'h0000; // R6
            end else begin
                nxt_st.crc_cnt = st_ff.crc_cnt + 14'h0001; // R6
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff           <= '0;
            st_ff.page_sel  <= `PXP1_PAGE_MAIN;
            st_ff.mode_ctl  <= `PXP1_MODE_CTL_RST;
            st_ff.sleep_ctl <= `PXP1_SLEEP_CTL_RST; // R12 R13 R14 R20 R21
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp  = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata  = st_ff.rdata;
    assign s_axi_rresp  = st_ff.rresp;
    assign page1_active = pg1;

    assign led_serial_mode   = st_ff.mode_ctl[`PXP1_B_LED_HI:`PXP1_B_LED_LO]; // R8
    assign led_release_blink = st_ff.blink; // R9
    // Pin enable and address swap take effect only on port zero
    assign fast_link_fail_en = st_ff.mode_ctl[`PXP1_B_FLF] && st_ff.port0_s2; // R10
    assign port_addr_swap    = st_ff.sleep_ctl[`PXP1_B_ADDR_REV] && st_ff.port0_s2; // R16
    // Reserved crossover code falls back to automatic
    assign mdi_mode = (st_ff.mode_ctl[`PXP1_B_MDI_HI:`PXP1_B_MDI_LO] == 2'h1)
        ? pxp1_pkg::PXP1_MDI_AUTO
        : pxp1_pkg::pxp1_mdi_e'(st_ff.mode_ctl[`PXP1_B_MDI_HI:`PXP1_B_MDI_LO]); // R11
    assign carrier_ext_disable = st_ff.sleep_ctl[`PXP1_B_CEXT_DIS]; // R12
    assign sleep_seconds = `PXP1_SLEEP_BASE_S
        + {1'b0, st_ff.sleep_ctl[`PXP1_B_SLEEP_HI:`PXP1_B_SLEEP_LO]}; // R13

    always_comb begin
        unique case (st_ff.sleep_ctl[`PXP1_B_WAKE_HI:`PXP1_B_WAKE_LO])
            2'h0: wake_ms = `PXP1_WAKE_160_MS; // R14
            2'h1: wake_ms = `PXP1_WAKE_400_MS;
            2'h2: wake_ms = `PXP1_WAKE_800_MS;
            2'h3: wake_ms = `PXP1_WAKE_2000_MS;
        endcase
    end

    assign slow_mgmt_clk    = st_ff.sleep_ctl[`PXP1_B_SLOW_MDC]; // R15
    assign no_preamble_10bt = st_ff.sleep_ctl[`PXP1_B_NO_PREAMBLE]; // R18
    assign downshift_en     = st_ff.sleep_ctl[`PXP1_B_DS_EN]; // R19
    assign downshift_tries  = `PXP1_DS_BASE_TRIES
        + {1'b0, st_ff.sleep_ctl[`PXP1_B_DS_HI:`PXP1_B_DS_LO]}; // R20
endmodule : pxp1_regs

// file: bench/pxp1_regs_properties.sv
/* Handshake and field checks of the page 1 register bank.
   Assumes binding onto pxp1_regs. */
`timescale 1ns/1ps
module pxp1_regs_chk (
    input wire logic                clk,
    input wire logic                srst,
    input wire logic [6:0]          s_axi_awaddr,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic [31:0]         s_axi_wdata,
    input wire logic [3:0]          s_axi_wstrb,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic                page1_active,
    input wire pxp1_pkg::pxp1_mdi_e mdi_mode,
    input wire logic [2:0]          sleep_seconds,
    input wire logic [2:0]          downshift_tries
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_wr; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
    sequence s_pg(v);
        s_wr ##0 (s_axi_awaddr == 7'h7C && s_axi_wstrb[1:0] == 2'h3 && s_axi_wdata[15:0] == v);
    endsequence
    property p_wr_ans; s_wr |=> s_axi_bvalid; endproperty
    property p_rd_ans; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_pg_on; s_pg(16'h0001) |=> page1_active; endproperty
    property p_pg_off; s_pg(16'h0000) |=> !page1_active; endproperty
    property p_mdi; mdi_mode != pxp1_pkg::PXP1_MDI_RSVD; endproperty
    property p_range; sleep_seconds inside {[3'h1:3'h4]} && downshift_tries inside {[3'h2:3'h5]}; endproperty
    property p_hi_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_refuse: assert property (p_refuse) else $error("write taken while busy");
    a_pg_on: assert property (p_pg_on) else $error("page 1 not selected");
    a_pg_off: assert property (p_pg_off) else $error("page 1 not released");
    a_mdi: assert property (p_mdi) else $error("reserved crossover code output");
    a_range: assert property (p_range) else $error("timer or tries out of range");
    a_hi_zero: assert property (p_hi_zero) else $error("upper read half not zero");
endmodule : pxp1_regs_chk
bind pxp1_regs pxp1_regs_chk pxp1_regs_chk_i (.clk(clk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .page1_active(page1_active), .mdi_mode(mdi_mode), .sleep_seconds(sleep_seconds),
    .downshift_tries(downshift_tries));

// file: bench/pxp1_pkt_src.sv
/* Copper receive side model: pulses good_crc_pkt n times, one every other clk.
   Assumes the register bank clock and reset. */
`timescale 1ns/1ps
module pxp1_pkt_src (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [15:0] n_pkts,
    input  wire logic        go,
    output logic             good_crc_pkt,
    output logic [1:0]       media_status,
    output logic             busy
);
    logic [15:0] left_ff;
    logic        pulse_ff;
    assign good_crc_pkt = pulse_ff;
    assign media_status = 2'h1;
    assign busy = (left_ff != 16'h0000) || pulse_ff;
    always_ff @(posedge clk) begin
        if (srst || go) begin
            left_ff <= srst ? 16'h0000 : n_pkts;
            pulse_ff <= 1'b0;
        end else if (!pulse_ff && left_ff != 16'h0000) begin
            pulse_ff <= 1'b1;
            left_ff <= left_ff - 16'h0001;
        end else begin
            pulse_ff <= 1'b0;
        end
    end
endmodule : pxp1_pkt_src

// file: bench/pxp1_regs_test.sv
/* Self-checking bench of the page 1 register bank over AXI4-Lite.
   Assumes pxp1_regs and the packet source model. */
`timescale 1ns/1ps
module pxp1_regs_test;
    logic clk = 0, srst = 1, soft_rst = 0, go = 0, ph = 1, p0 = 1;
    logic [6:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, pkt, blink;
    logic awready, wready, bvalid, arready, rvalid, page1_active, busy, got;
    logic [1:0] bresp, rresp, r, media;
    logic [15:0] n_pkts = 0;
    logic [3:0] led;
    logic flf, cext, slow, swp, nopre, ds_en;
    logic [2:0] slp, tries;
    logic [11:0] wake;
    pxp1_pkg::pxp1_mdi_e mdi;
    logic [11:0] wake_tab[4] = '{12'h0A0, 12'h190, 12'h320, 12'h7D0};
    logic [1:0] mdi_tab[4] = '{2'h0, 2'h0, 2'h2, 2'h3};
    int mismatches = 0, n_tests = 0, k, i;
    always #25 clk = ~clk;
    pxp1_regs pxp1_regs_i (.clk(clk), .srst(srst), .soft_rst(soft_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .good_crc_pkt(pkt),
        .media_status(media), .power_hold_input(ph), .port_zero_pin(p0),
        .page1_active(page1_active), .led_serial_mode(led), .led_release_blink(blink),
        .fast_link_fail_en(flf), .mdi_mode(mdi), .carrier_ext_disable(cext),
        .sleep_seconds(slp), .wake_ms(wake), .slow_mgmt_clk(slow), .port_addr_swap(swp),
        .no_preamble_10bt(nopre), .downshift_en(ds_en), .downshift_tries(tries));
    pxp1_pkt_src pxp1_pkt_src_i (.clk(clk), .srst(srst), .n_pkts(n_pkts), .go(go),
        .good_crc_pkt(pkt), .media_status(media), .busy(busy));
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // A used-up wait bound counts a mismatch and ends the run
    task automatic expire(input int n, input int lim);
        if (n >= lim) begin
            mismatches++;
            $display("Error %0t: wait timed out", $time);
            tally_and_finish();
        end
    endtask : expire
    // Handshake signals are looked at 1 ns after an edge, where they stand until the next edge
    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        i = 0; #1;
        while (!(awready && wready) && i < 20) begin @(posedge clk); #1; i++; end
        expire(i, 20); @(posedge clk);
        awvalid <= 1'b0; wvalid <= 1'b0; @(posedge clk); bready <= 1'b1;
        i = 0; #1;
        while (!bvalid && i < 20) begin @(posedge clk); #1; i++; end
        expire(i, 20); @(posedge clk); bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a; arvalid <= 1'b1;
        i = 0; #1;
        while (!arready && i < 20) begin @(posedge clk); #1; i++; end
        expire(i, 20); @(posedge clk);
        arvalid <= 1'b0; @(posedge clk); rready <= 1'b1;
        i = 0; #1;
        while (!rvalid && i < 20) begin @(posedge clk); #1; i++; end
        expire(i, 20); v = rdata; rs = rresp; @(posedge clk); rready <= 1'b0;
    endtask : rd
    task automatic pkts(input logic [15:0] n);
        n_pkts <= n; go <= 1'b1; @(posedge clk); go <= 1'b0; @(posedge clk);
        i = 0; #1;
        while (busy && i < 25000) begin @(posedge clk); #1; i++; end
        expire(i, 25000); @(posedge clk);
    endtask : pkts
    initial begin
        got = 0; repeat (3) @(posedge clk); srst <= 1'b0;
        wr(7'h7C, 32'h0000_0001); chk(page1_active, 1);
        rd(7'h4C, d, r); chk(d, 32'h0000_0000);
        rd(7'h50, d, r); chk(d, 32'h0000_A044);
        for (k = 0; k < 4; k++) begin
            wr(7'h50, (k << 13) | (k << 11) | (k << 2) | 32'h0000_0630); rd(7'h50, d, r);
            chk(d, (k << 13) | (k << 11) | (k << 2) | 32'h0000_0670);
            chk({slp, wake, tries}, {k[2:0] + 3'h1, wake_tab[k], k[2:0] + 3'h2});
            chk({slow, swp, nopre, ds_en, cext}, 5'h1E);
            wr(7'h4C, 32'h0000_F810 | (k << 2)); chk({led, flf, mdi}, {5'h1F, mdi_tab[k]});
        end
        p0 <= 1'b0; repeat (3) @(posedge clk); chk({flf, swp}, 2'h0);
        p0 <= 1'b1; repeat (3) @(posedge clk); chk({flf, swp}, 2'h3);
        pkts(16'h0003); rd(7'h48, d, r); chk(d, 32'h0000_8003);
        rd(7'h48, d, r); chk(d, 32'h0000_0000);
        pkts(16'h2711); rd(7'h48, d, r); chk(d, 32'h0000_8001);
        rd(7'h49, d, r); chk(r, 2'h2);
        wr(7'h7C, 32'h0000_0000); chk(page1_active, 0);
        wr(7'h50, 32'h0000_0000); wr(7'h7C, 32'h0000_0001); rd(7'h50, d, r); chk(d, 32'h0000_7E7C);
        soft_rst <= 1'b1; @(posedge clk); soft_rst <= 1'b0;
        rd(7'h50, d, r); chk(d, 32'h0000_FE7C);
        wr(7'h4C, 32'h0000_0800); ph <= 1'b0; got = 0;
        repeat (10) begin @(posedge clk); #1; if (blink === 1'b1) got = 1; end
        chk(got, 1);
        @(posedge clk); ph <= 1'b1; repeat (5) @(posedge clk);
        wr(7'h4C, 32'h0000_0000); ph <= 1'b0; got = 0;
        repeat (10) begin @(posedge clk); #1; if (blink !== 1'b0) got = 1; end
        chk(got, 0);
        tally_and_finish();
    end
endmodule : pxp1_regs_test
